// file: logic/pmt_timer.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - The count advances on the instruction clock (mclk over four) through a 1, 4 or 16 prescaler.
// - Prescale select 00 gives 1, 01 gives 4, and 1x gives 16.
// - Count rises from zero and on the increment after equalling the period wraps to zero with a match.
// - Matches pass a 4-bit postscaler so the flag sets after one to sixteen matches.
// - Postscale select value plus one is the number of matches per flag.
// - The postscaled match sets the timer flag at bit 1 of the peripheral flag register.
// - Prescale and postscale counters clear on count write, control write and reset.
// - A control write leaves the count unchanged.
// - The count is read/write at any time and zero after reset.
// - The period is read/write and all ones after reset.
// - The timer runs only while run enable (control bit 2) is one.
// - Control bit 7 has no storage and reads zero.
// - The raw match, before postscaling, goes to the sync serial port.
// - Count and match are offered to the enhanced capture pwm unit as time base.
module pmt_timer import pmt_pkg::*; (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // time base and interrupt outputs
  output logic [7:0] timer_count_out,
  output logic match_out,
  output logic irq_out
);
  // ==========================================================
  // registers
  logic [7:0] timer_count;
  logic [7:0] timer_period;
  logic [6:0] timer_control;
  logic match_event_flag;
  logic match_event_enable;
  logic [1:0] instr_div;
  logic match;
  logic pre_pulse;
  logic post_pulse;
  logic ps_clear;
  logic instr_tick;
  logic [3:0] pre_last;

  wire wr_count = wr_in && (addr_in == PMT_ADDR_COUNT);
  wire wr_ctl = wr_in && (addr_in == PMT_ADDR_CONTROL);
  wire run_enable = timer_control[PMT_CTL_RUN];
  wire [1:0] prescale_select = timer_control[PMT_CTL_PRE_LO +: 2];
  wire [3:0] postscale_select = timer_control[PMT_CTL_POST_LO +: 4];

  assign ps_clear = wr_count || wr_ctl;

  function automatic logic [3:0] pre_decode(input logic [1:0] sel);
    if (sel[1]) begin
      pre_decode = PMT_PRE_DIV16;
    end else if (sel[0]) begin
      pre_decode = PMT_PRE_DIV4;
    end else begin
      pre_decode = 4'h0;
    end
  endfunction

  assign pre_last = pre_decode(prescale_select);

  // ==========================================================
  // instruction clock: one pulse every four mclk cycles
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end
  assign instr_tick = run_enable && (instr_div == PMT_INSTR_DIV);

  // ==========================================================
  // prescaler and postscaler
  pmt_divider #(.W(4)) u_pre (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .clr_in(ps_clear),
    .tick_in(instr_tick),
    .last_in(pre_last),
    .pulse_out(pre_pulse)
  );

  assign match = pre_pulse && (timer_count == timer_period) && !wr_count;

  pmt_divider #(.W(4)) u_post (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .clr_in(ps_clear),
    .tick_in(match),
    .last_in(postscale_select),
    .pulse_out(post_pulse)
  );

  // ==========================================================
  // count, period, control
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      timer_count <= PMT_COUNT_RST;
    end else if (wr_count) begin
      timer_count <= wdata_in;
    end else if (pre_pulse) begin
      // control writes never touch the count
      timer_count <= match ? 8'h00 : timer_count + 8'h01;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      timer_period <= PMT_PERIOD_RST;
    end else if (wr_in && addr_in == PMT_ADDR_PERIOD) begin
      timer_period <= wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      timer_control <= PMT_CONTROL_RST;
    end else if (wr_ctl) begin
      timer_control <= wdata_in[6:0];
    end
  end

  // ==========================================================
  // interrupt flag: set wins over write-one-to-clear
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      match_event_flag <= 1'b0;
    end else if (post_pulse) begin
      match_event_flag <= 1'b1;
    end else if (wr_in && addr_in == PMT_ADDR_FLAGS && wdata_in[PMT_FLAG_BIT]) begin
      match_event_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      match_event_enable <= 1'b0;
    end else if (wr_in && addr_in == PMT_ADDR_ENABLE) begin
      match_event_enable <= wdata_in[PMT_FLAG_BIT];
    end
  end

  assign irq_out = match_event_flag && match_event_enable;

  // ==========================================================
  // read port, one cycle latency; unmapped reads zero
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        PMT_ADDR_COUNT: rdata_out <= timer_count;
        PMT_ADDR_PERIOD: rdata_out <= timer_period;
        PMT_ADDR_CONTROL: rdata_out <= {1'b0, timer_control};
        PMT_ADDR_FLAGS: rdata_out <= {6'h00, match_event_flag, 1'b0};
        PMT_ADDR_ENABLE: rdata_out <= {6'h00, match_event_enable, 1'b0};
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ==========================================================
  // time base for serial port and pwm unit
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      match_out <= 1'b0;
      timer_count_out <= PMT_COUNT_RST;
    end else begin
      match_out <= match;
      timer_count_out <= timer_count;
    end
  end
endmodule
`default_nettype wire

// file: logic/pmt_pkg.sv
`default_nettype none
package pmt_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] PMT_ADDR_COUNT = 4'h0;
  localparam logic [3:0] PMT_ADDR_PERIOD = 4'h1;
  localparam logic [3:0] PMT_ADDR_CONTROL = 4'h2;
  localparam logic [3:0] PMT_ADDR_FLAGS = 4'h3;
  localparam logic [3:0] PMT_ADDR_ENABLE = 4'h4;
  // control field positions and the flag/enable register bit
  localparam int PMT_CTL_PRE_LO = 0;
  localparam int PMT_CTL_RUN = 2;
  localparam int PMT_CTL_POST_LO = 3;
  localparam int PMT_FLAG_BIT = 1;
  // reset values
  localparam logic [7:0] PMT_COUNT_RST = 8'h00;
  localparam logic [7:0] PMT_PERIOD_RST = 8'hFF;
  localparam logic [6:0] PMT_CONTROL_RST = 7'h00;
  // clock ratios
  localparam logic [1:0] PMT_INSTR_DIV = 2'h3;
  localparam logic [3:0] PMT_PRE_DIV4 = 4'h3;
  localparam logic [3:0] PMT_PRE_DIV16 = 4'hF;
endpackage
`default_nettype wire

// file: logic/pmt_divider.sv
`timescale 1ns/1ns
`default_nettype none
// free-running enable divider; cleared by clr_in
module pmt_divider #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // control
  input wire logic clr_in,
  input wire logic tick_in,
  input wire logic [W-1:0] last_in,
  // result
  output logic pulse_out
);
  logic [W-1:0] count;

  always_ff @(posedge mclk_in) begin
    if (rst_in || clr_in) begin
      count <= '0;
    end else if (tick_in) begin
      if (count >= last_in) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  assign pulse_out = tick_in && (count >= last_in);
endmodule
`default_nettype wire

// file: verif/pmt_timer_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// port checks
module pmt_timer_chk import pmt_pkg::*; (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [7:0] timer_count_out,
  input wire logic match_out,
  input wire logic irq_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // stop write, then three quiet cycles
  sequence s_stop;
    wr_in && addr_in == PMT_ADDR_CONTROL && !wdata_in[PMT_CTL_RUN] ##1 !wr_in [*3];
  endsequence
  AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not idle");
  AST_B7_ZERO: assert property (rd_in && addr_in == PMT_ADDR_CONTROL |=> !rdata_out[7])
    else $error("control bit 7 set");
  AST_MATCH_GAP: assert property (match_out |=> !match_out [*3])
    else $error("match faster than tick");
  // the count copy trails the match pulse by one cycle
  AST_MATCH_ZERO: assert property (match_out && !(wr_in && addr_in == PMT_ADDR_COUNT)
    |=> timer_count_out == 8'h00)
    else $error("match without wrap");
  AST_STOP: assert property (s_stop |-> $stable(timer_count_out))
    else $error("count moved while off");
  AST_CNT_WR: assert property (wr_in && addr_in == PMT_ADDR_COUNT
    |-> ##2 timer_count_out == $past(wdata_in, 2))
    else $error("count write lost");
  AST_IRQ_RISE: assert property ($rose(irq_out) && !$past(wr_in) |-> match_out)
    else $error("irq without match");
  AST_IRQ_HOLD: assert property ($fell(irq_out) |-> $past(wr_in))
    else $error("irq dropped alone");
endmodule
bind pmt_timer pmt_timer_chk u_pmt_timer_chk (.mclk_in(mclk_in), .rst_in(rst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .timer_count_out(timer_count_out), .match_out(match_out), .irq_out(irq_out));
`default_nettype wire

// file: verif/tb_pmt_timer.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
// ==========
// bench
module tb_pmt_timer import pmt_pkg::*;;
  logic mclk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, rq = 0, match_out, irq_out;
  logic [3:0] addr_in = 4'h0;
  logic [3:0] ps[3] = '{4'h0, 4'hF, 4'h5};
  logic [7:0] wdata_in = 8'h00, rdata_out, timer_count_out, v, p, ev;
  int miscompares = 0, tests_run = 0, n, m;
  logic [7:0] eq[$];
  string nq[$], sv;
  pmt_timer u_pmt_timer (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .timer_count_out(timer_count_out), .match_out(match_out), .irq_out(irq_out));
  initial begin
    forever #10 mclk_in = ~mclk_in;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in) wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string s);
    addr_in <= a;
    rd_in <= 1'b1;
    eq.push_back(e);
    nq.push_back(s);
    @(posedge mclk_in) rd_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  // waits for the next match, bounded
  task automatic wm(output int k);
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (match_out !== 1'b1 && k < 3000);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    if (rq && eq.size() > 0) begin
      ev = eq.pop_front();
      sv = nq.pop_front();
      `CHK(sv, ev, rdata_out)
    end
    rq <= rd_in;
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    miscompares++;
    end_sim();
  end
  initial begin
    n = $urandom(32'h43B6F426);
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    rd(PMT_ADDR_COUNT, 8'h00, "count");
    rd(PMT_ADDR_PERIOD, 8'hFF, "period");
    rd(4'hF, 8'h00, "unmapped");
    v = 8'($urandom);
    wr(PMT_ADDR_COUNT, v);
    wr(PMT_ADDR_CONTROL, 8'hFB);
    rd(PMT_ADDR_CONTROL, 8'h7B, "control");
    rd(PMT_ADDR_COUNT, v, "count");
    for (int i = 0; i < 4; i++) begin
      p = 8'($urandom_range(5, 1));
      wr(PMT_ADDR_PERIOD, p);
      rd(PMT_ADDR_PERIOD, p, "period");
      wr(PMT_ADDR_COUNT, 8'h00);
      wr(PMT_ADDR_CONTROL, 8'(4 + i));
      wm(n);
      wm(n);
      `CHK("period", 4 * (p + 1) * (i == 0 ? 1 : i == 1 ? 4 : 16), n)
    end
    ps[2] = 4'($urandom);
    wr(PMT_ADDR_ENABLE, 8'h02);
    foreach (ps[j]) begin
      wr(PMT_ADDR_CONTROL, 8'h00);
      wr(PMT_ADDR_FLAGS, 8'h02);
      wr(PMT_ADDR_COUNT, 8'h00);
      wr(PMT_ADDR_CONTROL, {1'b0, ps[j], 3'b100});
      m = 0;
      n = 0;
      while (irq_out !== 1'b1 && n < 5000) begin
        @(posedge mclk_in);
        n++;
        if (match_out === 1'b1) m++;
      end
      `CHK("postscale", int'(ps[j]) + 1, m)
      // raw match stands in the same cycle as the new irq
      `CHK("match", 1'b1, match_out)
      @(posedge mclk_in);
      rd(PMT_ADDR_FLAGS, 8'h02, "flag");
    end
    wr(PMT_ADDR_ENABLE, 8'h00);
    `CHK("irq", 1'b0, irq_out)
    wr(PMT_ADDR_CONTROL, 8'h00);
    wr(PMT_ADDR_FLAGS, 8'h02);
    rd(PMT_ADDR_FLAGS, 8'h00, "flag");
    // let the last read compare before the run ends
    @(posedge mclk_in);
    end_sim();
  end
endmodule
`default_nettype wire
